// File: sim/local_bus_sink.sv
// Local controller bus model that takes commands and data halves
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module local_bus_sink (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic cmd_valid,
  input  wire logic wvalid,
  output logic      cmd_ready,
  output logic      wready
);
  // Take commands, halves
  // Slow mode stalls at random so the bridge must hold its outputs
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_ready <= 1'b0;
      wready    <= 1'b0;
    end
    else
    begin
      cmd_ready <= #1 !slow || $urandom_range(1);
      wready    <= #1 !slow || $urandom_range(1);
    end
  end
endmodule

// File: sim/memory_axi_address_bridge_tb.sv
// Self-checking bench for the memory address bridge
`timescale 1ns/1ps
`include "bridge_consts.svh"
module memory_axi_address_bridge_tb;
  import bridge_pkg::*;
  logic          clock = 0, nrst = 0, x8_mode = 0, slow = 0;
  logic [1:0]    port_clock_select_control = 0, clk_sel_q;
  logic          noc_valid = 0, noc_csr_space = 0, route_valid_q;
  logic [41:0]   noc_addr = 0;
  route_type     route_q;
  logic          csr_valid_q, awvalid = 0, awready_q, wvalid = 0;
  logic [6:0]    awid = 0, arid = 0, bid_q;
  logic [32:0]   awaddr = 0, araddr = 0;
  logic [7:0]    awlen = 0, arlen = 0;
  logic [2:0]    awsize = 0, arsize = 0;
  logic [1:0]    awburst = 0, arburst = 0, bresp_q;
  logic          wready_q, wlast = 0, bvalid_q, bready = 0;
  logic [511:0]  wdata = 0;
  logic [63:0]   wstrb = 0;
  logic          arvalid = 0, arready_q, lcl_cmd_valid_q, lcl_cmd_ready;
  lcl_cmd_type   lcl_cmd_q;
  logic          lcl_wvalid_q, lcl_wready, lcl_wlast_q;
  logic [255:0]  lcl_wdata_q;
  logic [31:0]   lcl_wstrb_q;
  int            errors = 0, n_compared = 0;
  lcl_cmd_type   cq[$];
  logic [288:0]  wq[$];
  route_type     sm_route;
  logic          sm_awready, sm_arready, sm_wready;

  always #50 clock = ~clock;

  memory_axi_address_bridge #(.SMALL_DEVICE(1'b0), .SUBSYS_INDEX(3'h1),
    .ID_W(7)) u_dut (.clock, .nrst, .x8_mode, .port_clock_select_control,
    .clk_sel_q, .noc_valid, .noc_csr_space, .noc_addr, .route_valid_q,
    .route_q, .csr_valid_q, .awvalid, .awready_q, .awid, .awaddr, .awlen,
    .awsize, .awburst, .wvalid, .wready_q, .wdata, .wstrb, .wlast,
    .bvalid_q, .bready, .bid_q, .bresp_q, .arvalid, .arready_q, .arid,
    .araddr, .arlen, .arsize, .arburst, .lcl_cmd_valid_q, .lcl_cmd_ready,
    .lcl_cmd_q, .lcl_wvalid_q, .lcl_wready, .lcl_wdata_q, .lcl_wstrb_q,
    .lcl_wlast_q);

  local_bus_sink u_sink (.clock, .nrst, .slow, .cmd_valid(lcl_cmd_valid_q),
    .wvalid(lcl_wvalid_q), .cmd_ready(lcl_cmd_ready), .wready(lcl_wready));

  // Small part: three-subsystem decode and no direct port
  memory_axi_address_bridge #(.SMALL_DEVICE(1'b1), .SUBSYS_INDEX(3'h1),
    .ID_W(7)) u_small (.clock, .nrst, .x8_mode, .port_clock_select_control,
    .clk_sel_q(), .noc_valid, .noc_csr_space, .noc_addr, .route_valid_q(),
    .route_q(sm_route), .csr_valid_q(), .awvalid, .awready_q(sm_awready),
    .awid, .awaddr, .awlen, .awsize, .awburst, .wvalid,
    .wready_q(sm_wready), .wdata, .wstrb, .wlast, .bvalid_q(), .bready,
    .bid_q(), .bresp_q(), .arvalid, .arready_q(sm_arready), .arid, .araddr,
    .arlen, .arsize, .arburst, .lcl_cmd_valid_q(), .lcl_cmd_ready,
    .lcl_cmd_q(), .lcl_wvalid_q(), .lcl_wready, .lcl_wdata_q(),
    .lcl_wstrb_q(), .lcl_wlast_q());

  // Everything the controller side accepts, in order
  always @(posedge clock)
  begin
    if (lcl_cmd_valid_q && lcl_cmd_ready)
      cq.push_back(lcl_cmd_q);
    if (lcl_wvalid_q && lcl_wready)
      wq.push_back({lcl_wlast_q, lcl_wstrb_q, lcl_wdata_q});
  end
////////////////////////////////////////////////////////////
  task automatic chk(input logic [511:0] seen, input logic [511:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t ns seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return awready_q;
      1: return wready_q;
      2: return bvalid_q;
      3: return arready_q;
      default: return cq.size() != 0;
    endcase
  endfunction

  task automatic wait_hi(input int k);
    int n;
    for (n = 0; n < 60 && sig(k) !== 1'b1; n++)
      step();
    if (n == 60)
    begin
      errors++;
      $display("[ERR] %0t ns wait %0d timed out", $time, k);
      give_verdict();
    end
  endtask

  function automatic logic [511:0] rnd;
    for (int i = 0; i < 16; i++)
      rnd[i*32 +: 32] = $urandom;
  endfunction

  // Decoder model: subsystem by code bits 3:1, east side flips channel
  function automatic route_type exp_route(input logic [3:0] c);
    automatic int map[8] = '{2, 6, 1, 5, 3, 7, 0, 4};
    route_type r;
    r.hit = 1'b1;
    r.err = 1'b0;
    r.subsys = 3'(map[c[3:1]]);
    r.chan = (r.subsys < 3'h4) ? c[0] : !c[0];
    return r;
  endfunction

  // Small part model: pairs 000x, 010x, 110x; channel follows bit 33
  function automatic route_type exp_small(input logic [3:0] c);
    route_type r;
    r = '0;
    r.hit = (c[3:1] == 3'h0) || (c[3:1] == 3'h2) || (c[3:1] == 3'h6);
    r.subsys = (c[3:1] == 3'h2) ? 3'h1 : (c[3:1] == 3'h6) ? 3'h2 : 3'h0;
    r.chan = r.hit && c[0];
    return r;
  endfunction

  function automatic lcl_cmd_type mk_cmd(input logic w, input logic [6:0] id,
    input logic [32:0] a, input logic [7:0] len, input logic x8);
    lcl_cmd_type c;
    c.write = w;
    c.id = id;
    c.len = len;
    c.size = 3'h6;
    c.burst = 2'h1;
    c.row = x8 ? a[30:16] : {1'b0, a[29:16]};
    c.bank = a[15:12];
    c.col = a[11:5];
    c.byte_sel = a[4:0];
    return c;
  endfunction
////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [32:0] a, input logic x8, input int nb);
    logic [288:0] ew[$];
    logic [511:0] d;
    logic [63:0]  s;
    x8_mode = x8;
    {awid, awaddr, awlen} = {7'($urandom), a, 8'(nb - 1)};
    {awsize, awburst, awvalid} = {3'h6, 2'h1, 1'b1};
    wait_hi(0);
    chk({sm_awready, sm_arready, sm_wready}, 3'h0);
    step();
    awvalid = 0;
    chk(awready_q, 1'b0);
    // One wide beat feeds two narrow halves
    for (int b = 0; b < nb; b++)
    begin
      d = rnd();
      s = d[63:0] ^ 64'h5A5A;
      {wdata, wstrb, wlast, wvalid} = {d, s, b == nb - 1, 1'b1};
      ew.push_back({1'b0, s[31:0], d[255:0]});
      ew.push_back({wlast, s[63:32], d[511:256]});
      wait_hi(1);
      step();
    end
    // Valid stays up between beats; ready low keeps the next beat waiting
    wvalid = 0;
    wait_hi(2);
    bready = 1;
    chk(bresp_q, |(x8 ? a[32:31] : a[32:30]) ? 2'h2 : 2'h0);
    chk(bid_q, awid);
    step();
    bready = 0;
    wait_hi(4);
    chk(cq.pop_front(), mk_cmd(1'b1, awid, a, awlen, x8));
    chk(wq.size(), ew.size());
    while (ew.size() != 0 && wq.size() != 0)
      chk(wq.pop_front(), ew.pop_front());
  endtask

  task automatic axi_read(input logic [32:0] a, input logic x8);
    x8_mode = x8;
    {arid, araddr, arlen, arsize} = {7'($urandom), a, 8'h3, 3'h6};
    {arburst, arvalid} = {2'h1, 1'b1};
    wait_hi(3);
    step();
    arvalid = 0;
    wait_hi(4);
    chk(cq.pop_front(), mk_cmd(1'b0, arid, a, 8'h3, x8));
  endtask
////////////////////////////////////////////////////////////
  initial
  begin
    logic [32:0] a;
    void'($urandom(54));
    repeat (4) @(posedge clock);
    chk({awready_q, wready_q, bvalid_q, lcl_cmd_valid_q}, 0);
    #1 nrst = 1;
    port_clock_select_control = 2'h2;
    step();
    chk(clk_sel_q, 2'h2);
    $display("test clock select done");
    noc_valid = 1;
    for (int c = 0; c < 16; c++)
    begin
      noc_addr = {5'h0, 4'(c), 33'(rnd())};
      step();
      chk(route_valid_q, 1'b1);
      chk(route_q, exp_route(4'(c)));
      chk(sm_route, exp_small(4'(c)));
    end
    noc_addr[41:37] = 5'h10;
    step();
    chk({route_q.hit, route_q.err}, 2'b01);
    chk({sm_route.hit, sm_route.err}, 2'b01);
    noc_csr_space = 1;
    step();
    chk({csr_valid_q, route_valid_q}, 2'b10);
    {noc_valid, noc_csr_space} = 2'b00;
    step();
    chk({csr_valid_q, route_valid_q}, 2'b00);
    $display("test decoder done");
    for (int i = 0; i < 4; i++)
    begin
      slow = i[1];
      // Top bits clear; test 2 sets bit 30 in x16
      a = 33'(rnd()) & 33'h03FFFFFFF;
      a[30] = i[1];
      axi_write(a, i[0], i + 1);
      axi_read(a ^ 33'h1F, i[0]);
      $display("test transfer %0d done", i);
    end
    axi_write(33'h100000000, 1'b1, 1);
    $display("test high address done");
    give_verdict();
  end
endmodule

// File: verilog/bridge_consts.svh
// Address field positions, codes and reset values for the memory bridge
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH

`define NOC_ADDR_W       42
`define NOC_ZERO_HI      41
`define NOC_ZERO_LO      37
`define CODE_HI          36
`define CODE_LO          33
`define CHAN_BIT         33
`define MEM_ADDR_W       33
`define ROW_HI_X8        30
`define ROW_HI_X16       29
`define ROW_LO           16
`define BANK_HI          15
`define BANK_LO          12
`define COL_HI           11
`define COL_LO           5
`define BYTE_HI          4
`define BYTE_LO          0
`define AXI_DATA_W       512
`define LCL_DATA_W       256
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define CLK_SEL_RESET    2'h0

`endif

// File: verilog/bridge_pkg.sv
// Types shared by the memory address bridge
package bridge_pkg;

  typedef struct packed {
    logic       hit;
    logic       err;
    logic [2:0] subsys;
    logic       chan;
  } route_type;

  typedef struct packed {
    logic        write;
    logic [6:0]  id;
    logic [7:0]  len;
    logic [2:0]  size;
    logic [1:0]  burst;
    logic [14:0] row;
    logic [3:0]  bank;
    logic [6:0]  col;
    logic [4:0]  byte_sel;
  } lcl_cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WDATA = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_RESP  = 3'b100
  } wstate_type;

endpackage

// File: verilog/memory_axi_address_bridge.sv
// Target decoder and direct fabric AXI port bridge for the memory subsystem
`timescale 1ns/1ps
`include "bridge_consts.svh"

// Functional notes
// - Large part: codes 1100..0101 to subsystems 0,1
// - Large part: codes 0000..1001 to subsystems 2,3
// - Large part: codes 1111..0110 to subsystems 4,5
// - Large part: codes 0011..1010 to subsystems 6,7
// - Small part: three subsystems, channel 0 first
// - West odd code channel 1, east even
// - Register space uses a separate mapping
// - Direct port only on subsystems 1,2,5,6
// - Direct port is 512-bit AXI4 responder
// - Write side runs half local-bus beat rate
// - Holding register narrows 512-bit words to 256-bit halves
// - Clock source choice from configuration control
// - AXI transactions become local bus commands
// - Per-channel memory address is 33 bits
// - x16: row 29:16, bank, column, byte
// - x8: row widens to 30:16
// - Bits 36:34 controller, bit 33 channel
module memory_axi_address_bridge
  import bridge_pkg::*;
#(
  parameter bit          SMALL_DEVICE = 1'b0,
  parameter logic [2:0]  SUBSYS_INDEX = 3'h1,
  parameter int unsigned ID_W         = 7
)(
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   x8_mode,
  input  wire logic [1:0]             port_clock_select_control,
  output      logic [1:0]             clk_sel_q,
  input  wire logic                   noc_valid,
  input  wire logic                   noc_csr_space,
  input  wire logic [`NOC_ADDR_W-1:0] noc_addr,
  output      logic                   route_valid_q,
  output      bridge_pkg::route_type  route_q,
  output      logic                   csr_valid_q,
  input  wire logic                   awvalid,
  output      logic                   awready_q,
  input  wire logic [ID_W-1:0]        awid,
  input  wire logic [`MEM_ADDR_W-1:0] awaddr,
  input  wire logic [7:0]             awlen,
  input  wire logic [2:0]             awsize,
  input  wire logic [1:0]             awburst,
  input  wire logic                   wvalid,
  output      logic                   wready_q,
  input  wire logic [`AXI_DATA_W-1:0] wdata,
  input  wire logic [63:0]            wstrb,
  input  wire logic                   wlast,
  output      logic                   bvalid_q,
  input  wire logic                   bready,
  output      logic [ID_W-1:0]        bid_q,
  output      logic [1:0]             bresp_q,
  input  wire logic                   arvalid,
  output      logic                   arready_q,
  input  wire logic [ID_W-1:0]        arid,
  input  wire logic [`MEM_ADDR_W-1:0] araddr,
  input  wire logic [7:0]             arlen,
  input  wire logic [2:0]             arsize,
  input  wire logic [1:0]             arburst,
  output      logic                   lcl_cmd_valid_q,
  input  wire logic                   lcl_cmd_ready,
  output      bridge_pkg::lcl_cmd_type lcl_cmd_q,
  output      logic                   lcl_wvalid_q,
  input  wire logic                   lcl_wready,
  output      logic [`LCL_DATA_W-1:0] lcl_wdata_q,
  output      logic [31:0]            lcl_wstrb_q,
  output      logic                   lcl_wlast_q
);
  import bridge_pkg::*;

  // Port present only on middle subsystems
  localparam bit PORT_ON = !SMALL_DEVICE &&
    (SUBSYS_INDEX == 3'h1 || SUBSYS_INDEX == 3'h2 ||
     SUBSYS_INDEX == 3'h5 || SUBSYS_INDEX == 3'h6);

  ////////////////////////////////////////////////////////////////////////
  // Target decode

  function automatic route_type decode(input logic [`NOC_ADDR_W-1:0] a);
    route_type r;
    logic [3:0] code;
    r = '0;
    code = a[`CODE_HI:`CODE_LO];
    r.err = |a[`NOC_ZERO_HI:`NOC_ZERO_LO];
    r.hit = !r.err;
    if (SMALL_DEVICE)
    begin
      unique case (code[3:1])
        3'b000: r.subsys = 3'h0;
        3'b010: r.subsys = 3'h1;
        3'b110: r.subsys = 3'h2;
        default: r.hit = 1'b0;
      endcase
      r.chan = a[`CHAN_BIT];
    end
    else
    begin
      unique case (code[3:1])
        3'b110: r.subsys = 3'h0;
        3'b010: r.subsys = 3'h1;
        3'b000: r.subsys = 3'h2;
        3'b100: r.subsys = 3'h3;
        3'b111: r.subsys = 3'h4;
        3'b011: r.subsys = 3'h5;
        3'b001: r.subsys = 3'h6;
        3'b101: r.subsys = 3'h7;
        default: r.subsys = 3'h0;
      endcase
      r.chan = r.subsys[2] ? !a[`CHAN_BIT] : a[`CHAN_BIT];
    end
    if (!r.hit)
    begin
      r.subsys = 3'h0;
      r.chan = 1'b0;
    end
    return r;
  endfunction

  // Split a channel address; the unused top bits are the initiator's job
  function automatic lcl_cmd_type split(
    input logic                   wr,
    input logic [ID_W-1:0]        id,
    input logic [`MEM_ADDR_W-1:0] a,
    input logic [7:0]             len,
    input logic [2:0]             size,
    input logic [1:0]             burst,
    input logic                   x8
  );
    lcl_cmd_type c;
    c = '0;
    c.write = wr;
    c.id = 7'(id);
    c.len = len;
    c.size = size;
    c.burst = burst;
    if (x8)
      c.row = a[`ROW_HI_X8:`ROW_LO];
    else
      c.row = {1'b0, a[`ROW_HI_X16:`ROW_LO]};
    c.bank = a[`BANK_HI:`BANK_LO];
    c.col = a[`COL_HI:`COL_LO];
    c.byte_sel = a[`BYTE_HI:`BYTE_LO];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decoder outputs

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      route_valid_q <= 1'b0;
      route_q <= '0;
      csr_valid_q <= 1'b0;
    end
    else
    begin
      route_valid_q <= noc_valid && !noc_csr_space;
      csr_valid_q <= noc_valid && noc_csr_space;
      route_q <= (noc_valid && !noc_csr_space) ? decode(noc_addr) : '0;
    end
  end

  // Clock source choice held for the clock mux
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      clk_sel_q <= `CLK_SEL_RESET;
    else
      clk_sel_q <= port_clock_select_control;
  end

  ////////////////////////////////////////////////////////////////////////
  // Direct port handshakes

  wstate_type state_q;
  wstate_type state_d;
  logic       rd_turn_q;
  logic       last_q;
  logic       err_q;
  logic [`LCL_DATA_W-1:0] hi_data_q;
  logic [31:0]            hi_strb_q;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic cmd_fire;
  logic lw_fire;
  logic b_fire;
  logic cmd_busy_d;
  logic base_ready;

  assign aw_fire = awvalid && awready_q;
  assign w_fire = wvalid && wready_q;
  assign ar_fire = arvalid && arready_q;
  assign cmd_fire = lcl_cmd_valid_q && lcl_cmd_ready;
  assign lw_fire = lcl_wvalid_q && lcl_wready;
  assign b_fire = bvalid_q && bready;
  assign cmd_busy_d = (lcl_cmd_valid_q && !lcl_cmd_ready) ||
                      aw_fire || ar_fire;
  // Single command slot full drops readies
  assign base_ready = PORT_ON && state_d == ST_IDLE && !cmd_busy_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (aw_fire) state_d = ST_WDATA;
      ST_WDATA: if (w_fire) state_d = ST_LOW;
      ST_LOW:   if (lw_fire) state_d = ST_HIGH;
      ST_HIGH:  if (lw_fire) state_d = last_q ? ST_RESP : ST_WDATA;
      ST_RESP:  if (b_fire) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      rd_turn_q <= 1'b0;
      awready_q <= 1'b0;
      arready_q <= 1'b0;
      wready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // Alternating turns keep both address channels from firing at once
      rd_turn_q <= !rd_turn_q;
      awready_q <= base_ready && rd_turn_q;
      arready_q <= base_ready && !rd_turn_q;
      // One wide beat per two narrow halves
      wready_q <= PORT_ON && state_d == ST_WDATA && !w_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local command

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lcl_cmd_valid_q <= 1'b0;
      lcl_cmd_q <= '0;
      err_q <= 1'b0;
      bid_q <= '0;
    end
    else
    begin
      lcl_cmd_valid_q <= cmd_busy_d;
      // Translate address phase to local command
      if (aw_fire)
      begin
        lcl_cmd_q <= split(1'b1, awid, awaddr, awlen, awsize, awburst,
                           x8_mode);
        bid_q <= awid;
        // Flag addresses beyond the channel density
        err_q <= x8_mode ? |awaddr[32:31] : |awaddr[32:30];
      end
      else if (ar_fire)
        lcl_cmd_q <= split(1'b0, arid, araddr, arlen, arsize, arburst,
                           x8_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data narrowing

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lcl_wvalid_q <= 1'b0;
      lcl_wdata_q <= '0;
      lcl_wstrb_q <= '0;
      lcl_wlast_q <= 1'b0;
      hi_data_q <= '0;
      hi_strb_q <= '0;
      last_q <= 1'b0;
    end
    else
    begin
      lcl_wvalid_q <= state_d == ST_LOW || state_d == ST_HIGH;
      // Low half first, then high half
      if (w_fire)
      begin
        lcl_wdata_q <= wdata[`LCL_DATA_W-1:0];
        lcl_wstrb_q <= wstrb[31:0];
        hi_data_q <= wdata[`AXI_DATA_W-1:`LCL_DATA_W];
        hi_strb_q <= wstrb[63:32];
        last_q <= wlast;
        lcl_wlast_q <= 1'b0;
      end
      else if (lw_fire && state_q == ST_LOW)
      begin
        lcl_wdata_q <= hi_data_q;
        lcl_wstrb_q <= hi_strb_q;
        lcl_wlast_q <= last_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write response

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      bvalid_q <= state_d == ST_RESP;
      bresp_q <= err_q ? `RESP_SLVERR : `RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_no_port;
    @(posedge clock) disable iff (!nrst)
    !PORT_ON |-> !awready_q && !arready_q && !wready_q;
  endproperty
  a_no_port: assert property (p_no_port)
    else $error("direct port active on wrong subsystem");

  property p_one_addr;
    @(posedge clock) disable iff (!nrst)
    !(awready_q && arready_q);
  endproperty
  a_one_addr: assert property (p_one_addr)
    else $error("both address readies high");

  property p_cmd;
    @(posedge clock) disable iff (!nrst)
    aw_fire |=> lcl_cmd_valid_q && lcl_cmd_q.write &&
      lcl_cmd_q.bank == $past(awaddr[15:12]) &&
      lcl_cmd_q.col == $past(awaddr[11:5]);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("write command fields wrong");

  property p_row_x8;
    @(posedge clock) disable iff (!nrst)
    aw_fire && x8_mode |=> lcl_cmd_q.row == $past(awaddr[30:16]);
  endproperty
  a_row_x8: assert property (p_row_x8)
    else $error("x8 row field wrong");

  // Checked per accepted low half, so stalls of any length are covered
  property p_halves;
    @(posedge clock) disable iff (!nrst)
    lw_fire && state_q == ST_LOW
      |=> lcl_wvalid_q && lcl_wdata_q == $past(hi_data_q) &&
        lcl_wstrb_q == $past(hi_strb_q);
  endproperty
  a_halves: assert property (p_halves)
    else $error("high half did not follow low half");

  property p_csr;
    @(posedge clock) disable iff (!nrst)
    noc_valid && noc_csr_space |=> csr_valid_q && !route_valid_q;
  endproperty
  a_csr: assert property (p_csr)
    else $error("register access decoded as memory");

  property p_parity;
    @(posedge clock) disable iff (!nrst)
    noc_valid && !noc_csr_space && !SMALL_DEVICE &&
      noc_addr[41:37] == 5'h00
      |=> route_q.hit &&
        route_q.chan == ($past(noc_addr[33]) ^ route_q.subsys[2]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("channel parity wrong");

  property p_topbits;
    @(posedge clock) disable iff (!nrst)
    noc_valid && !noc_csr_space && |noc_addr[41:37]
      |=> route_q.err && !route_q.hit;
  endproperty
  a_topbits: assert property (p_topbits)
    else $error("reserved target bits not flagged");

  c_write: cover property (@(posedge clock) disable iff (!nrst)
    aw_fire ##[1:40] b_fire);
  c_read: cover property (@(posedge clock) disable iff (!nrst)
    ar_fire ##1 cmd_fire);
  c_route: cover property (@(posedge clock) disable iff (!nrst)
    route_valid_q && route_q.hit && route_q.chan);

endmodule
